// ---- hdl/serial_status_error_mp_flags.sv ----
// Serial unit with parity error, transmit end and multiprocessor bit flags
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flags_consts.svh"
module serial_status_error_mp_flags
    import serial_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic standby,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic txd_out,
    output logic txd_oe,
    input wire logic rxd_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic irq
);
    localparam unit_state_t UNIT_RESET = '{
        tx_state: LINK_IDLE,
        rx_state: LINK_IDLE,
        tx_shift: 11'h7FF,
        tx_empty_flag: 1'b1,
        transmit_end_flag: 1'b1,
        div: `DIV_RESET,
        pctl: `PCTL_RESET,
        rxd_prev: 1'b1,
        default: '0
    };

    unit_state_t s_reg;
    unit_state_t s_next;
    logic tx_restart;
    logic rx_restart;
    logic tx_last;
    logic rx_done;
    logic par_bad;
    logic [3:0] ev;
    logic [10:0] rx_sh;
    logic [10:0] rx_fr;
    logic [7:0] rx_data;
    logic rx_xbit;
    logic sync_mode;
    logic extra_bit;
    logic tx_xbit;
    logic sck_rd;
    logic rxd_rd;
    logic st_wr;

    bit_tick_if tx_tk();
    bit_tick_if rx_tk();

    bit_ticker u_tx_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .port(tx_tk)
    );

    bit_ticker u_rx_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .port(rx_tk)
    );

    // Both tickers share the software divisor
    assign tx_tk.divisor = s_reg.div;
    assign rx_tk.divisor = s_reg.div;
    assign tx_tk.restart = tx_restart;
    assign rx_tk.restart = rx_restart;

    // Frame shape from the mode register
    assign sync_mode = s_reg.mode[`MODE_SYNC];
    assign extra_bit = !sync_mode && (s_reg.mode[`MODE_PAR_EN] || s_reg.mode[`MODE_MP]);
    assign st_wr = reg_write && (reg_addr == `OFS_STATUS);

    // The multiprocessor bit takes the parity slot, so only one of them is sent
    assign tx_xbit = s_reg.mode[`MODE_MP] ? s_reg.tx_multiproc_bit : (^s_reg.tdr ^ s_reg.mode[`MODE_ODD]);

    // Received frame alignment; a frame without the extra bit sits one place higher
    assign rx_sh = {rxd_in, s_reg.rx_shift[10:1]};
    assign rx_fr = extra_bit ? rx_sh : {1'b1, rx_sh[10:1]};
    assign rx_data = sync_mode ? rx_sh[10:3] : rx_fr[8:1];
    assign rx_xbit = rx_fr[9];

    // Parity is checked in async parity frames only
    assign par_bad = !sync_mode && s_reg.mode[`MODE_PAR_EN] && !s_reg.mode[`MODE_MP] &&
                     ((^rx_data ^ rx_xbit) != s_reg.mode[`MODE_ODD]);

    // Port data read-back of the clock and receive pins
    assign sck_rd = (s_reg.pctl[3:2] == `PMD_IN) ? sck_in : s_reg.pdata[1];
    assign rxd_rd = s_reg.ctrl[`CTRL_RE] ? rxd_in : s_reg.pdata[0];

    // Pins: the serial engine owns TxD while transmit is enabled
    assign txd_out = s_reg.ctrl[`CTRL_TE] ? s_reg.tx_shift[0] :
                     ((s_reg.pctl[1:0] == `PMD_OUT) ? s_reg.pdata[0] : 1'b1);
    assign txd_oe = s_reg.ctrl[`CTRL_TE] || (s_reg.pctl[1:0] == `PMD_OUT);
    assign sck_oe = (sync_mode && s_reg.tx_state == LINK_BUSY) || (s_reg.pctl[3:2] == `PMD_OUT);
    assign sck_out = (sync_mode && s_reg.tx_state == LINK_BUSY) ? !tx_tk.low : s_reg.pdata[1];

    assign reg_rdata = s_reg.rdata;
    assign irq = |(s_reg.int_stat & s_reg.int_mask);

    // Next state; software clears come first so that hardware sets win
    always_comb begin
        s_next = s_reg;
        tx_restart = 1'b0;
        rx_restart = 1'b0;
        tx_last = 1'b0;
        rx_done = 1'b0;
        ev = 4'h0;
        s_next.rxd_prev = rxd_in;
        s_next.rdata = 8'h00;

        // Register reads; a status read arms the clear of the empty, full and parity error flags seen at one
        if (reg_read) begin
            case (reg_addr)
                `OFS_MODE: s_next.rdata = {4'h0, s_reg.mode};
                `OFS_CTRL: s_next.rdata = {6'h00, s_reg.ctrl};
                `OFS_STATUS: begin
                    s_next.rdata = {s_reg.tx_empty_flag, s_reg.rx_full_flag, 2'h0, s_reg.parity_error_flag, s_reg.transmit_end_flag, s_reg.rx_multiproc_bit, s_reg.tx_multiproc_bit};
                    s_next.arm_tx_empty_flag = s_reg.tx_empty_flag;
                    s_next.arm_rx_full_flag = s_reg.rx_full_flag;
                    s_next.arm_per = s_reg.parity_error_flag;
                end
                `OFS_TXDATA: s_next.rdata = s_reg.tdr;
                `OFS_RXDATA: s_next.rdata = s_reg.rdr;
                `OFS_PCTL: s_next.rdata = {4'h0, s_reg.pctl};
                `OFS_PDATA: s_next.rdata = {6'h00, sck_rd, rxd_rd};
                `OFS_DIV: s_next.rdata = s_reg.div;
                `OFS_INT_STAT: s_next.rdata = {4'h0, s_reg.int_stat};
                `OFS_INT_MASK: s_next.rdata = {4'h0, s_reg.int_mask};
                default: s_next.rdata = 8'h00;
            endcase
        end

        // Register writes
        if (reg_write) begin
            case (reg_addr)
                `OFS_MODE: s_next.mode = reg_wdata[3:0];
                `OFS_CTRL: s_next.ctrl = reg_wdata[1:0];
                `OFS_STATUS: begin
                    // Transmit end and received multiprocessor bit take no write
                    if (s_reg.arm_tx_empty_flag && !reg_wdata[`ST_TX_EMPTY_FLAG]) begin
                        s_next.tx_empty_flag = 1'b0;
                        s_next.transmit_end_flag = 1'b0;
                    end
                    if (s_reg.arm_rx_full_flag && !reg_wdata[`ST_RX_FULL_FLAG]) begin
                        s_next.rx_full_flag = 1'b0;
                    end
                    if (s_reg.arm_per && !reg_wdata[`ST_PER]) begin
                        s_next.parity_error_flag = 1'b0;
                    end
                    s_next.tx_multiproc_bit = reg_wdata[`ST_TX_MULTIPROC_BIT];
                    s_next.arm_tx_empty_flag = 1'b0;
                    s_next.arm_rx_full_flag = 1'b0;
                    s_next.arm_per = 1'b0;
                end
                `OFS_TXDATA: s_next.tdr = reg_wdata;
                `OFS_PCTL: s_next.pctl = reg_wdata[3:0];
                `OFS_PDATA: s_next.pdata = reg_wdata[1:0];
                `OFS_DIV: s_next.div = reg_wdata;
                `OFS_INT_STAT: s_next.int_stat = s_reg.int_stat & ~reg_wdata[3:0];
                `OFS_INT_MASK: s_next.int_mask = reg_wdata[3:0];
                default: s_next.int_mask = s_next.int_mask;
            endcase
        end

        // Transmitter; a parity error holds it only in sync mode
        case (s_reg.tx_state)
            LINK_IDLE: begin
                if (s_reg.ctrl[`CTRL_TE] && !s_reg.tx_empty_flag && !(sync_mode && s_reg.parity_error_flag)) begin
                    // The extra bit is latched here, so later writes do not disturb a frame
                    if (sync_mode) begin
                        s_next.tx_shift = {3'h7, s_reg.tdr};
                        s_next.tx_bits = `FRAME_SYNC;
                    end else if (extra_bit) begin
                        s_next.tx_shift = {1'b1, tx_xbit, s_reg.tdr, 1'b0};
                        s_next.tx_bits = `FRAME_ASYNC_X;
                    end else begin
                        s_next.tx_shift = {2'h3, s_reg.tdr, 1'b0};
                        s_next.tx_bits = `FRAME_ASYNC;
                    end
                    s_next.tx_empty_flag = 1'b1;
                    ev[`INT_TXE] = 1'b1;
                    tx_restart = 1'b1;
                    s_next.tx_state = LINK_BUSY;
                end
            end
            LINK_BUSY: begin
                if (tx_tk.tick) begin
                    s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                    s_next.tx_bits = s_reg.tx_bits - 4'h1;
                    if (s_reg.tx_bits == 4'h1) begin
                        tx_last = 1'b1;
                        s_next.tx_state = LINK_IDLE;
                    end
                end
            end
            default: s_next.tx_state = LINK_IDLE;
        endcase

        // Last bit out with nothing waiting ends the transmission
        if (tx_last && s_reg.tx_empty_flag) begin
            s_next.transmit_end_flag = 1'b1;
            ev[`INT_TRANSMIT_END_FLAG] = 1'b1;
        end

        // Dropping transmit enable aborts the frame and marks the end
        if (!s_next.ctrl[`CTRL_TE]) begin
            s_next.tx_state = LINK_IDLE;
            s_next.tx_shift = 11'h7FF;
        end
        if (s_reg.ctrl[`CTRL_TE] && !s_next.ctrl[`CTRL_TE]) begin
            s_next.transmit_end_flag = 1'b1;
        end

        // Receiver; a pending parity error blocks any new frame
        case (s_reg.rx_state)
            LINK_IDLE: begin
                if (s_reg.ctrl[`CTRL_RE] && !s_reg.parity_error_flag) begin
                    if (sync_mode) begin
                        rx_restart = 1'b1;
                        s_next.rx_bits = `FRAME_SYNC;
                        s_next.rx_state = LINK_BUSY;
                    end else if (s_reg.rxd_prev && !rxd_in) begin
                        // Start bit edge realigns sampling to mid-bit
                        rx_restart = 1'b1;
                        s_next.rx_bits = extra_bit ? `FRAME_ASYNC_X : `FRAME_ASYNC;
                        s_next.rx_state = LINK_BUSY;
                    end
                end
            end
            LINK_BUSY: begin
                if (rx_tk.mid) begin
                    s_next.rx_shift = rx_sh;
                    s_next.rx_bits = s_reg.rx_bits - 4'h1;
                    if (s_reg.rx_bits == 4'h1) begin
                        rx_done = 1'b1;
                        s_next.rx_state = LINK_IDLE;
                    end
                end
            end
            default: s_next.rx_state = LINK_IDLE;
        endcase

        // Frame end: the receiver sets flags only here, so receive disable leaves them alone
        if (rx_done) begin
            if (!sync_mode && s_reg.mode[`MODE_MP]) begin
                s_next.rx_multiproc_bit = rx_xbit;
            end
            if (par_bad) begin
                s_next.parity_error_flag = 1'b1;
                s_next.rdr = rx_data;
                ev[`INT_PER] = 1'b1;
            end else if (!s_reg.rx_full_flag) begin
                s_next.rdr = rx_data;
                s_next.rx_full_flag = 1'b1;
                ev[`INT_RX] = 1'b1;
            end
        end

        // Receive disable abandons a frame; flag and bit values are kept
        if (!s_next.ctrl[`CTRL_RE]) begin
            s_next.rx_state = LINK_IDLE;
        end

        // Sticky interrupt status, set over clear
        s_next.int_stat = s_next.int_stat | ev;

        // Standby forces the empty, full, parity error and transmit end flags to their reset values and stops both engines
        if (standby) begin
            s_next.parity_error_flag = 1'b0;
            s_next.transmit_end_flag = 1'b1;
            s_next.tx_empty_flag = 1'b1;
            s_next.rx_full_flag = 1'b0;
            s_next.tx_state = LINK_IDLE;
            s_next.rx_state = LINK_IDLE;
            s_next.tx_shift = 11'h7FF;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= UNIT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_per_detect: assert property ((rx_done && par_bad && !standby) |=> s_reg.parity_error_flag)
        else $error("Parity mismatch did not set parity error");

    a_per_standby: assert property (standby |=> !s_reg.parity_error_flag && s_reg.rx_state == LINK_IDLE)
        else $error("Parity error survived standby");

    a_per_clear_seq: assert property ((st_wr && s_reg.arm_per && !reg_wdata[`ST_PER] && !rx_done)
        |=> !s_reg.parity_error_flag)
        else $error("Read then write zero did not clear parity error");

    a_per_sticky: assert property ((s_reg.parity_error_flag && !standby && !st_wr) |=> s_reg.parity_error_flag)
        else $error("Parity error dropped without clear sequence");

    a_per_no_full: assert property ((rx_done && par_bad && !s_reg.rx_full_flag && !standby)
        |=> !s_reg.rx_full_flag && s_reg.rdr == $past(rx_data))
        else $error("Parity error frame handled wrongly");

    a_rx_halt: assert property ((s_reg.parity_error_flag && s_reg.rx_state == LINK_IDLE) |=> s_reg.rx_state == LINK_IDLE)
        else $error("Receiver restarted while parity error set");

    a_sync_tx_halt: assert property ((sync_mode && s_reg.parity_error_flag && s_reg.tx_state == LINK_IDLE)
        |=> s_reg.tx_state == LINK_IDLE)
        else $error("Sync transmitter started while parity error set");

    a_transmit_end_flag_no_write: assert property ((st_wr && s_reg.transmit_end_flag && !(s_reg.arm_tx_empty_flag && !reg_wdata[`ST_TX_EMPTY_FLAG]))
        |=> s_reg.transmit_end_flag)
        else $error("Write changed transmit end");

    a_transmit_end_flag_clear: assert property ((st_wr && s_reg.arm_tx_empty_flag && !reg_wdata[`ST_TX_EMPTY_FLAG] && !tx_last
        && !standby && s_reg.ctrl[`CTRL_TE]) |=> !s_reg.transmit_end_flag || !s_reg.ctrl[`CTRL_TE])
        else $error("Empty flag clear left transmit end set");

    a_transmit_end_flag_standby: assert property (standby |=> s_reg.transmit_end_flag && s_reg.tx_empty_flag)
        else $error("Transmit end not set by standby");

    a_transmit_end_flag_te_off: assert property ((reg_write && reg_addr == `OFS_CTRL && s_reg.ctrl[`CTRL_TE]
        && !reg_wdata[`CTRL_TE]) |=> s_reg.transmit_end_flag ##1 s_reg.tx_state == LINK_IDLE)
        else $error("Transmit disable did not set transmit end");

    a_transmit_end_flag_tx_end: assert property ((tx_last && s_reg.tx_empty_flag) |=> s_reg.transmit_end_flag)
        else $error("Transmit end missing after last bit");

    a_mpb_held: assert property ((!rx_done && !standby) |=> $stable(s_reg.rx_multiproc_bit))
        else $error("Received multiprocessor bit changed outside frame end");
endmodule
`default_nettype wire

// ---- hdl/serial_flags_consts.svh ----
// Register offsets, field positions, reset values and frame lengths of the serial unit
`ifndef SERIAL_FLAGS_CONSTS_SVH
`define SERIAL_FLAGS_CONSTS_SVH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_TXDATA 8'h0C
`define OFS_RXDATA 8'h10
`define OFS_PCTL 8'h14
`define OFS_PDATA 8'h18
`define OFS_DIV 8'h1C
`define OFS_INT_STAT 8'h20
`define OFS_INT_MASK 8'h24

// Mode register fields
`define MODE_SYNC 0
`define MODE_PAR_EN 1
`define MODE_ODD 2
`define MODE_MP 3

// Control register fields
`define CTRL_TE 0
`define CTRL_RE 1

// Status register fields
`define ST_TX_EMPTY_FLAG 7
`define ST_RX_FULL_FLAG 6
`define ST_PER 3
`define ST_TRANSMIT_END_FLAG 2
`define ST_MPB 1
`define ST_TX_MULTIPROC_BIT 0

// Interrupt event positions
`define INT_RX 0
`define INT_PER 1
`define INT_TXE 2
`define INT_TRANSMIT_END_FLAG 3

// Pin port modes, two bits per pin
`define PMD_OUT 2'h1
`define PMD_IN 2'h2

// Reset values
`define PCTL_RESET 4'h8
`define DIV_RESET 8'hFF

// Frame lengths in bit times
`define FRAME_SYNC 4'h8
`define FRAME_ASYNC 4'hA
`define FRAME_ASYNC_X 4'hB

`endif

// ---- hdl/serial_flags_pkg.sv ----
// Types shared by the serial unit and its bit ticker
package serial_flags_pkg;

    typedef enum logic {LINK_IDLE, LINK_BUSY} link_state_t;

    typedef struct packed {
        logic [7:0] cnt;
    } tick_state_t;

    typedef struct packed {
        link_state_t tx_state;
        link_state_t rx_state;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [10:0] rx_shift;
        logic [3:0] rx_bits;
        logic [7:0] tdr;
        logic [7:0] rdr;
        logic [3:0] mode;
        logic [1:0] ctrl;
        logic [7:0] div;
        logic [3:0] pctl;
        logic [1:0] pdata;
        logic tx_empty_flag;
        logic rx_full_flag;
        logic parity_error_flag;
        logic transmit_end_flag;
        logic rx_multiproc_bit;
        logic tx_multiproc_bit;
        logic arm_tx_empty_flag;
        logic arm_rx_full_flag;
        logic arm_per;
        logic [3:0] int_stat;
        logic [3:0] int_mask;
        logic [7:0] rdata;
        logic rxd_prev;
    } unit_state_t;

endpackage

// ---- hdl/bit_tick_if.sv ----
// Bit timing carrier between the serial unit and a ticker
`timescale 1ns/1ps
`default_nettype none
interface bit_tick_if;
    logic [7:0] divisor;
    logic restart;
    logic tick;
    logic mid;
    logic low;
    modport gen (input divisor, input restart, output tick, output mid, output low);
    modport host (output divisor, output restart, input tick, input mid, input low);
endinterface
`default_nettype wire

// ---- hdl/bit_ticker.sv ----
// Bit period counter with end, middle and first-half markers
`timescale 1ns/1ps
`default_nettype none
module bit_ticker
    import serial_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    bit_tick_if.gen port
);
    tick_state_t s_reg;
    tick_state_t s_next;

    // Markers decode the registered counter, so they follow a restart one clock later
    assign port.tick = (s_reg.cnt == port.divisor);
    assign port.mid = (s_reg.cnt == (port.divisor >> 1));
    assign port.low = (s_reg.cnt <= (port.divisor >> 1));

    // A restart realigns the period to a line edge
    always_comb begin
        s_next = s_reg;
        if (port.restart || port.tick) begin
            s_next.cnt = 8'h00;
        end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '{cnt: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

// ---- bench/serial_line_partner.sv ----
// Remote serial transceiver model on the receive and transmit lines
`timescale 1ns/1ps
`default_nettype none
module serial_line_partner #(
    parameter int BIT_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic txd_out,
    input wire logic txd_oe,
    output logic rxd_in
);
    // Line rests at mark level between frames, as a pulled-up line would
    initial rxd_in = 1'b1;

    // Start, eight data bits LSB first, optional parity or multiprocessor bit, stop
    task automatic send(input logic [7:0] d, input logic ex, input bit has_ex);
        logic [10:0] f;
        int n;
        f = {1'b1, ex, d, 1'b0};
        n = has_ex ? 11 : 10;
        if (!has_ex) f[9] = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) rxd_in <= f[i];
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk) rxd_in <= 1'b1;
    endtask

    // Waits, bounded, for a start bit then samples each bit near its middle
    task automatic catch_frame(input int n, output logic [10:0] f, output bit ok);
        int w;
        f = '0;
        w = 0;
        while (!(txd_oe === 1'b1 && txd_out === 1'b0) && w < 4000) begin
            @(posedge ref_clk);
            #1;
            w++;
        end
        ok = (w < 4000);
        repeat (BIT_CYC / 2) @(posedge ref_clk);
        #1;
        for (int i = 0; i < n; i++) begin
            f[i] = txd_out;
            repeat (BIT_CYC) @(posedge ref_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/test_serial_status_error_mp_flags.sv ----
// Self-checking bench for the serial unit flags, pin port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "serial_flags_consts.svh"
module test_serial_status_error_mp_flags;
    logic ref_clk, reset, standby, reg_write, reg_read, sck_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic txd_out, txd_oe, rxd_in, sck_out, sck_oe, irq;
    logic [10:0] fr;
    bit ok;
    int n_mismatch = 0;
    int comparisons = 0;

    serial_status_error_mp_flags uut (.ref_clk(ref_clk), .reset(reset), .standby(standby),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_in), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq));
    serial_line_partner #(.BIT_CYC(4)) far (.ref_clk(ref_clk), .txd_out(txd_out), .txd_oe(txd_oe),
        .rxd_in(rxd_in));

    // 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Register bus: one-cycle strobes changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Masked read compare; a status read also arms the clear sequence
    task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_reg(a);
        check(what, rd & m, e);
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need well under 5000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        standby = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sck_in = 1'b0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        chk_reg("status", `OFS_STATUS, 8'hFF, 8'h84);
        wr(`OFS_STATUS, 8'h82);
        chk_reg("status", `OFS_STATUS, 8'hFF, 8'h84);
        chk_reg("unmapped", 8'h30, 8'hFF, 8'h00);
        done("reset");
        // Even parity, clean frame
        wr(`OFS_DIV, 8'h03);
        wr(`OFS_MODE, 8'h02);
        wr(`OFS_CTRL, 8'h02);
        far.send(8'h5A, 1'b0, 1);
        chk_reg("status", `OFS_STATUS, 8'h4A, 8'h40);
        chk_reg("rx data", `OFS_RXDATA, 8'hFF, 8'h5A);
        wr(`OFS_STATUS, 8'h80);
        // Odd parity, clean then wrong
        wr(`OFS_MODE, 8'h06);
        far.send(8'h01, 1'b0, 1);
        chk_reg("status", `OFS_STATUS, 8'h48, 8'h40);
        wr(`OFS_STATUS, 8'h80);
        far.send(8'h3C, 1'b0, 1);
        chk_reg("status", `OFS_STATUS, 8'h48, 8'h08);
        chk_reg("rx data", `OFS_RXDATA, 8'hFF, 8'h3C);
        chk_reg("int status", `OFS_INT_STAT, 8'h02, 8'h02);
        check("irq", {7'h0, irq}, 8'h00);
        wr(`OFS_INT_MASK, 8'h02);
        @(posedge ref_clk);
        #1;
        check("irq", {7'h0, irq}, 8'h01);
        wr(`OFS_CTRL, 8'h00);
        wr(`OFS_CTRL, 8'h02);
        chk_reg("status", `OFS_STATUS, 8'h08, 8'h08);
        far.send(8'h11, 1'b1, 1);
        chk_reg("rx data", `OFS_RXDATA, 8'hFF, 8'h3C);
        chk_reg("status", `OFS_STATUS, 8'h48, 8'h08);
        wr(`OFS_STATUS, 8'h88);
        wr(`OFS_STATUS, 8'h80);
        chk_reg("status", `OFS_STATUS, 8'h08, 8'h08);
        wr(`OFS_STATUS, 8'h80);
        chk_reg("status", `OFS_STATUS, 8'h08, 8'h00);
        wr(`OFS_INT_STAT, 8'h0F);
        @(posedge ref_clk);
        #1;
        check("irq", {7'h0, irq}, 8'h00);
        done("parity");
        // Multiprocessor receive and keep on receive disable
        wr(`OFS_MODE, 8'h08);
        far.send(8'hA5, 1'b1, 1);
        chk_reg("status", `OFS_STATUS, 8'h42, 8'h42);
        chk_reg("rx data", `OFS_RXDATA, 8'hFF, 8'hA5);
        wr(`OFS_CTRL, 8'h00);
        chk_reg("status", `OFS_STATUS, 8'h02, 8'h02);
        done("mp receive");
        // Multiprocessor transmit; the empty-flag clear also clears transmit end
        wr(`OFS_CTRL, 8'h01);
        wr(`OFS_TXDATA, 8'hC3);
        fork
            far.catch_frame(11, fr, ok);
            begin
                rd_reg(`OFS_STATUS);
                wr(`OFS_STATUS, 8'h01);
                chk_reg("status", `OFS_STATUS, 8'h05, 8'h01);
            end
        join
        check("start seen", {7'h0, ok}, 8'h01);
        check("tx data", fr[8:1], 8'hC3);
        check("tx mp bit", {7'h0, fr[9]}, 8'h01);
        check("framing", {6'h0, fr[10], fr[0]}, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk_reg("status", `OFS_STATUS, 8'h84, 8'h84);
        wr(`OFS_TXDATA, 8'h5A);
        rd_reg(`OFS_STATUS);
        wr(`OFS_STATUS, 8'h00);
        wr(`OFS_CTRL, 8'h00);
        chk_reg("status", `OFS_STATUS, 8'h04, 8'h04);
        done("transmit");
        // Standby while a pending parity error holds a byte unsent
        wr(`OFS_MODE, 8'h02);
        wr(`OFS_CTRL, 8'h03);
        far.send(8'h01, 1'b0, 1);
        // Sync mode with the error pending: the byte must stay unsent
        wr(`OFS_MODE, 8'h01);
        wr(`OFS_TXDATA, 8'h33);
        rd_reg(`OFS_STATUS);
        wr(`OFS_STATUS, 8'h08);
        chk_reg("status", `OFS_STATUS, 8'h8C, 8'h08);
        standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        standby <= 1'b0;
        chk_reg("status", `OFS_STATUS, 8'hCC, 8'h84);
        done("standby");
        // Pin port: drive TxD and clock pin, then read both inputs
        wr(`OFS_CTRL, 8'h00);
        wr(`OFS_PCTL, 8'h05);
        wr(`OFS_PDATA, 8'h02);
        repeat (2) @(posedge ref_clk);
        #1;
        check("pins", {4'h0, txd_oe, txd_out, sck_oe, sck_out}, 8'h0B);
        wr(`OFS_PCTL, 8'h08);
        wr(`OFS_CTRL, 8'h02);
        sck_in <= 1'b1;
        chk_reg("port data", `OFS_PDATA, 8'h03, 8'h03);
        sck_in <= 1'b0;
        chk_reg("port data", `OFS_PDATA, 8'h03, 8'h01);
        done("pin port");
        give_verdict();
    end
endmodule
`default_nettype wire
